// ### rtl/eeir_pkg.sv
// Constants shared by the event interrupt routing block.
// Assumes a 32-bit classic Wishbone bus with 8-bit registers in the low bits.
package eeir_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PIN1_ROUTE_LOW = 8'h20;
	localparam logic [7:0] IDX_PIN1_ROUTE_HIGH = 8'h0c;
	localparam logic [7:0] IDX_PIN2_EMB_ROUTE = 8'h0e;
	localparam logic [7:0] IDX_PIN1_ROUTE_CONFIG = 8'h5e;
	localparam logic [7:0] IDX_PIN2_ROUTE_CONFIG = 8'h5f;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h22;

	// Reset value of every register
	localparam logic [7:0] ROUTE_RESET = 8'h00;

	// Master enable position inside both pin config registers
	localparam int MASTER_EN_BIT = 1;

	// Second pin embedded route field positions
	localparam int P2_LONG_COUNTER_BIT = 7;
	localparam int P2_SIG_MOTION_BIT = 5;
	localparam int P2_INCLINE_BIT = 4;
	localparam int P2_PACE_BIT = 3;

	// Bits software must keep at zero in the second pin route register
	localparam logic [7:0] P2_RESERVED_MASK = 8'h47;

	// Interrupt status and mask layout
	localparam int IRQ_PIN1_RISE_BIT = 0;
	localparam int IRQ_PIN2_RISE_BIT = 1;
	localparam int IRQ_RESERVED_WR_BIT = 2;
	localparam int IRQ_W = 3;

endpackage : eeir_pkg

// ### rtl/eeir_route_or.sv
// One interrupt pin: OR of the events whose route bit is set.
// Assumes events and routes are synchronous to clock.
`timescale 1ns/100ps
module eeir_route_or
	import eeir_pkg::*;
#(
	parameter int N = 8
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Event sources and selection
	input wire logic [N-1:0] events,
	input wire logic [N-1:0] route,
	input wire logic master_en,
	// Pin level
	output logic pin
);

	// Whole state of the pin driver
	typedef struct packed
	{
		logic pin;
	} eeir_pin_state_t;

	eeir_pin_state_t st;
	eeir_pin_state_t next_st;

	// Selected events merged, gated by the master enable
	always_comb
	begin
		next_st = st;
		next_st.pin = master_en & (|(events & route));
	end

	// Register the pin so the output is glitch free
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			st <= '0; // Pin held low through reset
		else
			st <= next_st;
	end

	assign pin = st.pin;

	// Pin follows its routed events one cycle later
	pin_or_a: assert property (@(posedge clock) disable iff (sys_rst)
		##1 pin == $past(master_en && ((events & route) != '0)))
		else $error("pin does not follow routed events");

endmodule : eeir_route_or

// ### rtl/eeir_top.sv
// Embedded event interrupt routing with a Wishbone register slave.
// Assumes synchronous event levels and a classic single-cycle master.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module eeir_top
	import eeir_pkg::*;
#(
	parameter int ENGINES = 16,
	parameter int ADR_W = 10
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Event sources
	input wire logic [ENGINES-1:0] engine_event,
	input wire logic long_counter_event,
	input wire logic significant_motion_event,
	input wire logic incline_event,
	input wire logic pace_event,
	// Interrupt pins
	output logic first_irq_pin,
	output logic second_irq_pin,
	// Bus interrupt
	output logic irq
);

	// Whole register and control state
	typedef struct packed
	{
		logic [7:0] route_low; // Engines 8..1
		logic [7:0] route_high; // Engines 16..9
		logic [7:0] route2; // Embedded events, second pin
		logic [7:0] cfg1; // First pin config
		logic [7:0] cfg2; // Second pin config
		logic [IRQ_W-1:0] status; // Sticky events
		logic [IRQ_W-1:0] mask; // Interrupt mask
		logic pin1_prev; // Edge detect history
		logic pin2_prev;
		logic ack;
		logic [31:0] dat;
		logic irq;
	} eeir_state_t;

	eeir_state_t st;
	eeir_state_t next_st;

	// Word index from a byte address, used by read and write decode
	function automatic logic [7:0] eeir_index(input logic [ADR_W-1:0] a);
		eeir_index = a[9:2];
	endfunction : eeir_index

	// Pin drivers and their inputs
	logic pin1_q;
	logic pin2_q;
	logic [ENGINES-1:0] pin1_events;
	logic [ENGINES-1:0] pin1_route;
	logic [7:0] pin2_events;

	// Request decode
	logic take;
	logic wr_lane0;
	logic [7:0] idx;
	logic [7:0] rd_byte;
	logic [IRQ_W-1:0] set_ev;
	logic [IRQ_W-1:0] clr_ev;

	// Engine events concatenated, sixteen down to one
	assign pin1_events = engine_event;
	// Route high holds 16..9, route low 8..1
	assign pin1_route = {st.route_high, st.route_low};

	// Embedded event vector in route register layout; reserved bits idle
	always_comb
	begin
		pin2_events = 8'h00;
		pin2_events[P2_LONG_COUNTER_BIT] = long_counter_event;
		pin2_events[P2_SIG_MOTION_BIT] = significant_motion_event;
		pin2_events[P2_INCLINE_BIT] = incline_event;
		pin2_events[P2_PACE_BIT] = pace_event;
	end

	// First pin: engine events
	eeir_route_or #(
		.N(ENGINES)
	) u_pin1 (
		.clock(clock),
		.sys_rst(sys_rst),
		.events(pin1_events),
		.route(pin1_route),
		.master_en(st.cfg1[MASTER_EN_BIT]),
		.pin(pin1_q)
	);

	// Second pin: embedded function events
	eeir_route_or #(
		.N(8)
	) u_pin2 (
		.clock(clock),
		.sys_rst(sys_rst),
		.events(pin2_events),
		.route(st.route2),
		.master_en(st.cfg2[MASTER_EN_BIT]),
		.pin(pin2_q)
	);

	// A new request is taken only while no answer is pending
	assign take = wb_cyc_i & wb_stb_i & ~st.ack;
	assign wr_lane0 = take & wb_we_i & wb_sel_i[0];
	assign idx = eeir_index(wb_adr_i);

	// Read multiplexer; unmapped words read zero
	always_comb
	begin
		case (idx)
			IDX_PIN1_ROUTE_LOW: rd_byte = st.route_low;
			IDX_PIN1_ROUTE_HIGH: rd_byte = st.route_high;
			IDX_PIN2_EMB_ROUTE: rd_byte = st.route2;
			IDX_PIN1_ROUTE_CONFIG: rd_byte = st.cfg1;
			IDX_PIN2_ROUTE_CONFIG: rd_byte = st.cfg2;
			IDX_IRQ_STATUS: rd_byte = {5'h00, st.status};
			IDX_IRQ_MASK: rd_byte = {5'h00, st.mask};
			default: rd_byte = 8'h00;
		endcase
	end

	// Events that set sticky status bits
	always_comb
	begin
		set_ev = '0;
		set_ev[IRQ_PIN1_RISE_BIT] = pin1_q & ~st.pin1_prev;
		set_ev[IRQ_PIN2_RISE_BIT] = pin2_q & ~st.pin2_prev;
		// Software slip on bits that must stay zero is flagged
		set_ev[IRQ_RESERVED_WR_BIT] = wr_lane0
			& (idx == IDX_PIN2_EMB_ROUTE)
			& ((wb_dat_i[7:0] & P2_RESERVED_MASK) != 8'h00);
	end

	// A read of the status register clears it
	assign clr_ev = (take && !wb_we_i && idx == IDX_IRQ_STATUS) ?
		'1 : '0;

	// Next state: bus answer, register writes, sticky status
	always_comb
	begin
		next_st = st;
		next_st.ack = take;
		next_st.dat = take ? {24'h000000, rd_byte} : 32'h00000000;
		next_st.pin1_prev = pin1_q;
		next_st.pin2_prev = pin2_q;
		// Writes take effect at the request edge; unmapped writes ignored
		if (wr_lane0)
		begin
			case (idx)
				IDX_PIN1_ROUTE_LOW:
					next_st.route_low = wb_dat_i[7:0];
				IDX_PIN1_ROUTE_HIGH:
					next_st.route_high = wb_dat_i[7:0];
				// Stored as written so software sees its own value
				IDX_PIN2_EMB_ROUTE:
					next_st.route2 = wb_dat_i[7:0];
				IDX_PIN1_ROUTE_CONFIG:
					next_st.cfg1 = wb_dat_i[7:0];
				IDX_PIN2_ROUTE_CONFIG:
					next_st.cfg2 = wb_dat_i[7:0];
				IDX_IRQ_MASK:
					next_st.mask = wb_dat_i[IRQ_W-1:0];
				default:
					next_st.mask = st.mask;
			endcase
		end
		// Set wins over a clearing read in the same cycle
		next_st.status = (st.status & ~clr_ev) | set_ev;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// Register the whole state; all routing starts disabled
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.route_low <= ROUTE_RESET;
			st.route_high <= ROUTE_RESET;
			st.route2 <= ROUTE_RESET;
			st.cfg1 <= ROUTE_RESET;
			st.cfg2 <= ROUTE_RESET;
		end
		else
			st <= next_st;
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;
	assign irq = st.irq;
	assign first_irq_pin = pin1_q;
	assign second_irq_pin = pin2_q;

	// Acknowledge is a single cycle pulse
	ack_one_cycle_a: assert property (@(posedge clock) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// Every taken request is answered on the next edge
	ack_latency_a: assert property (@(posedge clock) disable iff (sys_rst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");

	// Reset leaves all routing cleared
	route_reset_a: assert property (@(posedge clock)
		sys_rst |=> (st.route_low == 8'h00 && st.route_high == 8'h00
			&& st.route2 == 8'h00 && !first_irq_pin && !second_irq_pin))
		else $error("routing not cleared by reset");

	// A routing write reads back the written byte
	route_readback_a: assert property (@(posedge clock)
		disable iff (sys_rst)
		(wr_lane0 && idx == IDX_PIN2_EMB_ROUTE)
			|=> st.route2 == $past(wb_dat_i[7:0]))
		else $error("route register lost written value");

	// Engine sixteen routed through the high register
	engine_high_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg1[MASTER_EN_BIT] && st.route_high[7]
			&& engine_event[ENGINES-1]) |=> first_irq_pin)
		else $error("engine sixteen not routed");

	// Engine one routed through the low register
	engine_low_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg1[MASTER_EN_BIT] && st.route_low[0]
			&& engine_event[0]) |=> first_irq_pin)
		else $error("engine one not routed");

	// Without master enable the first pin stays low
	pin1_gate_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		!st.cfg1[MASTER_EN_BIT] |=> !first_irq_pin)
		else $error("first pin active while disabled");

	// First pin carries exactly the routed OR
	pin1_or_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		##1 first_irq_pin == $past(st.cfg1[MASTER_EN_BIT]
			&& ((pin1_events & pin1_route) != '0)))
		else $error("first pin differs from routed OR");

	// Long counter timeout onto the second pin
	long_counter_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg2[MASTER_EN_BIT] && st.route2[P2_LONG_COUNTER_BIT]
			&& long_counter_event) |=> second_irq_pin)
		else $error("long counter event not routed");

	// Significant motion onto the second pin
	sig_motion_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg2[MASTER_EN_BIT] && st.route2[P2_SIG_MOTION_BIT]
			&& significant_motion_event) |=> second_irq_pin)
		else $error("significant motion not routed");

	// Incline onto the second pin
	incline_route_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg2[MASTER_EN_BIT] && st.route2[P2_INCLINE_BIT]
			&& incline_event) |=> second_irq_pin)
		else $error("incline event not routed");

	// Pace onto the second pin
	pace_route_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(st.cfg2[MASTER_EN_BIT] && st.route2[P2_PACE_BIT]
			&& pace_event) |=> second_irq_pin)
		else $error("pace event not routed");

	// Second pin carries exactly the routed OR
	pin2_or_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		##1 second_irq_pin == $past(st.cfg2[MASTER_EN_BIT]
			&& ((pin2_events & st.route2) != 8'h00)))
		else $error("second pin differs from routed OR");

	// Interrupt output tracks unmasked status
	irq_level_a: assert property (@(posedge clock) disable iff (sys_rst)
		irq == ((st.status & st.mask) != '0))
		else $error("irq does not match masked status");

	// Without its master enable the second pin stays low
	pin2_gate_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		!st.cfg2[MASTER_EN_BIT] |=> !second_irq_pin)
		else $error("second pin active while disabled");

	// A route read answers with the stored byte, upper bytes zero
	route_read_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(take && !wb_we_i && idx == IDX_PIN1_ROUTE_HIGH)
			|=> wb_dat_o == {24'h000000, $past(st.route_high)})
		else $error("route read returned wrong data");

	// Data lines rest at zero outside an answer
	dat_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
		!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero while idle");

	// A rising first pin leaves a sticky status bit
	pin1_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(first_irq_pin) |=> st.status[IRQ_PIN1_RISE_BIT])
		else $error("first pin rise not recorded");

	// A rising second pin leaves a sticky status bit
	pin2_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(second_irq_pin) |=> st.status[IRQ_PIN2_RISE_BIT])
		else $error("second pin rise not recorded");

	// A status read clears every bit not set again at that edge
	status_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
		(take && !wb_we_i && idx == IDX_IRQ_STATUS)
			|=> (st.status & ~$past(set_ev)) == '0)
		else $error("status read did not clear");

	// Nonzero reserved route bits raise the slip flag
	reserved_flag_a: assert property (
		@(posedge clock) disable iff (sys_rst)
		(wr_lane0 && idx == IDX_PIN2_EMB_ROUTE
			&& (wb_dat_i[7:0] & P2_RESERVED_MASK) != 8'h00)
			|=> st.status[IRQ_RESERVED_WR_BIT])
		else $error("reserved route write not flagged");

endmodule : eeir_top

// ### verif/eeir_host_model.sv
// Host side model: samples both interrupt pins and counts rising edges.
// Assumes pins are synchronous levels from the device on the same clock.
`timescale 1ns/100ps
module eeir_host_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Interrupt pins from the device
	input wire logic first_irq_pin,
	input wire logic second_irq_pin,
	// Rises seen by the host
	output int rise1,
	output int rise2
);
	logic last1, last2; // Levels at the previous edge
	// Level sampling; a pulse shorter than a cycle would be lost here
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			{last1, last2} <= 2'b00;
			rise1 <= 0;
			rise2 <= 0;
		end
		else
		begin
			last1 <= first_irq_pin;
			last2 <= second_irq_pin;
			rise1 <= rise1 + int'(first_irq_pin & !last1);
			rise2 <= rise2 + int'(second_irq_pin & !last2);
		end
	end
endmodule : eeir_host_model

// ### verif/embedded_event_irq_routing_tb.sv
// Bench: random routes and events against a behavioural model.
// Assumes the host model beside it and one 125 MHz clock.
`timescale 1ns/100ps
module embedded_event_irq_routing_tb
	import eeir_pkg::*;
;
	logic clock = 0, sys_rst = 1; // Clock and reset
	logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0; // Bus request
	logic [9:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
	logic wb_ack_o, first_irq_pin, second_irq_pin, irq; // Outputs
	logic [15:0] engine_event = '0; // Event sources
	logic long_counter_event = 0, significant_motion_event = 0;
	logic incline_event = 0, pace_event = 0;
	logic [7:0] lo, hi, r2, c1, c2; // Model copy of the routing
	logic e1, e2, p1 = 0, p2 = 0; // Model pins, now and before
	int rise1, rise2, m1 = 0, m2 = 0, n_mismatch = 0, check_count = 0;
	// Mapped registers except status, plus one unmapped index
	logic [7:0] idx [7] = '{IDX_PIN1_ROUTE_LOW, IDX_PIN1_ROUTE_HIGH,
		IDX_PIN2_EMB_ROUTE, IDX_PIN1_ROUTE_CONFIG, IDX_PIN2_ROUTE_CONFIG,
		IDX_IRQ_MASK, 8'h33};
	eeir_top dut (.clock, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.engine_event, .long_counter_event, .significant_motion_event,
		.incline_event, .pace_event, .first_irq_pin, .second_irq_pin, .irq);
	eeir_host_model host (.clock, .sys_rst, .first_irq_pin,
		.second_irq_pin, .rise1, .rise2);
	// Free running clock
	initial
	begin
		forever #4 clock = ~clock;
	end
	// Verdict and stop
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One classic cycle; held until ack, the wait is bounded
	task automatic wb(input logic we, input logic [7:0] ix,
		input logic [7:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
		wb_adr_i <= {ix, 2'b00};
		wb_dat_i <= {24'h0, wd};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (n >= 20)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wb
	// Write then read back
	task automatic wr(input logic [7:0] ix, input logic [7:0] v);
		wb(1'b1, ix, v, rd);
		wb(1'b0, ix, 8'h00, rd);
		chk(rd, {24'h0, v});
	endtask : wr
	// Load the model routing into the device
	task automatic wall;
		wr(IDX_PIN1_ROUTE_LOW, lo);
		wr(IDX_PIN1_ROUTE_HIGH, hi);
		wr(IDX_PIN2_EMB_ROUTE, r2);
		wr(IDX_PIN1_ROUTE_CONFIG, c1);
		wr(IDX_PIN2_ROUTE_CONFIG, c2);
	endtask : wall
	// Drive events, wait two rising edges for the registered pins, compare with the model
	task automatic drv(input logic [19:0] v);
		@(posedge clock);
		{long_counter_event, significant_motion_event, incline_event,
			pace_event, engine_event} <= v;
		repeat (2) @(posedge clock);
		@(negedge clock);
		e1 = c1[MASTER_EN_BIT] & |({hi, lo} & v[15:0]);
		e2 = c2[MASTER_EN_BIT] & |(r2 & {v[19], 1'b0, v[18:16], 3'b0});
		chk(first_irq_pin, e1);
		chk(second_irq_pin, e2);
		m1 += int'(e1 & !p1);
		m2 += int'(e2 & !p2);
		p1 = e1;
		p2 = e2;
	endtask : drv
	// Main sequence
	initial
	begin
		void'($urandom(23));
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		foreach (idx[i])
		begin
			wb(1'b0, idx[i], 8'h00, rd);
			chk(rd, 32'h0);
		end
		// Quiet pins while routing changes so rises stay countable
		for (int k = 0; k < 8; k++)
		begin
			drv(20'h0);
			{lo, hi, c1, c2} = $urandom;
			r2 = 8'($urandom) & 8'hb8;
			wall();
			for (int j = 0; j < 6; j++)
				drv(20'($urandom));
		end
		chk(rise1, m1);
		chk(rise2, m2);
		// Interrupt raised, cleared by read, then masked
		drv(20'h0);
		{lo, hi, r2, c1, c2} = 40'h01_00_00_02_00;
		wall();
		wr(IDX_IRQ_MASK, 8'h03);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
		drv(20'h1);
		chk(irq, 1'b1);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
		chk(rd, 32'h1);
		@(negedge clock);
		chk(irq, 1'b0);
		wr(IDX_IRQ_MASK, 8'h00);
		drv(20'h0);
		drv(20'h1);
		chk(irq, 1'b0);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
		chk(rd, 32'h1);
		// Reserved route bits written against the rule are flagged
		wb(1'b1, IDX_PIN2_EMB_ROUTE, 8'h47, rd);
		wb(1'b0, IDX_IRQ_STATUS, 8'h00, rd);
		chk(rd, 32'h4);
		end_of_test();
	end
endmodule : embedded_event_irq_routing_tb
